// ==== attach_props.sv ====
// Purpose: port checks for the attach control block
// Assumes: one clock, async active-low reset
// Notes: outputs settle one edge after their cause
module attach_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ready_to_enumerate_in,
  input wire logic self_powered_in,
  input wire logic pullup_source_select_key_in,
  input wire logic [3:0] pullup_pio_index_in,
  input wire logic max_power_override_in,
  input wire logic [7:0] max_power_request_key_in,
  input wire logic endpoint_set_select_in,
  input wire logic internal_pullup_enable_out,
  input wire logic [15:0] pio_out,
  input wire logic [15:0] pio_oe_out,
  input wire logic [7:0] max_power_report_out,
  input wire logic audio_endpoints_out,
  input wire logic host_role_out,
  input wire logic bus_power_present_out,
  input wire logic attached_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // three samples cover the state edge plus the output edge
  host_a: assert property (!host_role_out)
    else $error("host role output raised");
  ready_a: assert property (
    (!ready_to_enumerate_in)[*3] |-> !attached_out)
    else $error("attached while not ready");
  no_power_a: assert property (
    (self_powered_in && !bus_power_present_out)[*3] |-> !attached_out)
    else $error("attached without bus power");
  // registered outputs answer the configuration of the previous edge
  int_pullup_a: assert property (
    internal_pullup_enable_out == (attached_out &&
    ($past(pullup_source_select_key_in) == usb_attach_pkg::PULLUP_INTERNAL)))
    else $error("internal pull-up mismatch");
  ext_pullup_a: assert property (
    $past(pullup_source_select_key_in) |->
    pio_out[$past(pullup_pio_index_in)] == attached_out)
    else $error("external pull-up level mismatch");
  ext_oe_a: assert property (
    $past(resetn_in) && $past(pullup_source_select_key_in) |->
    pio_oe_out[$past(pullup_pio_index_in)])
    else $error("external pull-up pio not driven");
  def_power_a: assert property (
    !max_power_override_in |=>
    max_power_report_out == usb_attach_pkg::DEFAULT_MAX_POWER)
    else $error("default power mismatch");
  set_power_a: assert property (
    max_power_override_in |=>
    max_power_report_out == $past(max_power_request_key_in))
    else $error("set power mismatch");
  ep_set_a: assert property (
    1 |=> audio_endpoints_out == $past(endpoint_set_select_in))
    else $error("endpoint set mismatch");
  cover property ($rose(attached_out));
  cover property (pio_out[pullup_pio_index_in] && attached_out);
  cover property (audio_endpoints_out);
endmodule // attach_props
bind usb_attach_power_control attach_props u_props (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .ready_to_enumerate_in(ready_to_enumerate_in),
  .self_powered_in(self_powered_in),
  .pullup_source_select_key_in(pullup_source_select_key_in),
  .pullup_pio_index_in(pullup_pio_index_in),
  .max_power_override_in(max_power_override_in),
  .max_power_request_key_in(max_power_request_key_in),
  .endpoint_set_select_in(endpoint_set_select_in),
  .internal_pullup_enable_out(internal_pullup_enable_out),
  .pio_out(pio_out),
  .pio_oe_out(pio_oe_out),
  .max_power_report_out(max_power_report_out),
  .audio_endpoints_out(audio_endpoints_out),
  .host_role_out(host_role_out),
  .bus_power_present_out(bus_power_present_out),
  .attached_out(attached_out)
);

// ==== host_model.sv ====
// Purpose: host side: bus power through the sense divider
// Assumes: only the sense pin is driven
// Notes: other pins toggle so no stale level is trusted
module host_model (
  input wire logic clk_in,
  input wire logic vbus_on_in,
  input wire logic [3:0] sense_pin_in,
  output logic [15:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] noise_reg = 16'hA5A5;
  // undriven pins flip each cycle
  always @(posedge clk_in) noise_reg <= ~noise_reg;
  // divider shows bus power on the chosen pin only
  always_comb begin
    pins_out = noise_reg;
    pins_out[sense_pin_in] = vbus_on_in;
  end
endmodule // host_model

// ==== sync_two_ff.sv ====
// Purpose: two flip-flop synchroniser for one level from outside the clock
// Assumes: asynchronous active-low reset
// Notes: first stage is read only by the second
module sync_two_ff (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  // the metastable stage feeds nothing but the second stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sync_two_ff

// ==== tb.sv ====
// Purpose: self-checking bench for attach control
// Assumes: settle of about 127 edges
// Notes: pin indices fixed so lags stay known
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, resetn_in = 1'b0, ready_to_enumerate_in = 1'b0;
  logic self_powered_in = 1'b0, pullup_source_select_key_in = 1'b0;
  logic max_power_override_in = 1'b0, endpoint_set_select_in = 1'b0;
  logic [3:0] pullup_pio_index_in = 4'h3, bus_power_sense_pin_key_in = 4'h5;
  logic [7:0] max_power_request_key_in = 8'h64, max_power_report_out;
  logic [15:0] pio_pins_in, pio_out, pio_oe_out;
  logic internal_pullup_enable_out, audio_endpoints_out, host_role_out;
  logic bus_power_present_out, attached_out, vbus = 1'b0;
  int failures = 0, samples_checked = 0, cycles = 0;
  initial forever #4 clk_in = ~clk_in;
  host_model hm (
    .clk_in(clk_in),
    .vbus_on_in(vbus),
    .sense_pin_in(bus_power_sense_pin_key_in),
    .pins_out(pio_pins_in)
  );
  usb_attach_power_control dut (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ready_to_enumerate_in(ready_to_enumerate_in),
    .self_powered_in(self_powered_in),
    .pullup_source_select_key_in(pullup_source_select_key_in),
    .pullup_pio_index_in(pullup_pio_index_in),
    .bus_power_sense_pin_key_in(bus_power_sense_pin_key_in),
    .max_power_override_in(max_power_override_in),
    .max_power_request_key_in(max_power_request_key_in),
    .endpoint_set_select_in(endpoint_set_select_in),
    .pio_pins_in(pio_pins_in),
    .internal_pullup_enable_out(internal_pullup_enable_out),
    .pio_out(pio_out),
    .pio_oe_out(pio_oe_out),
    .max_power_report_out(max_power_report_out),
    .audio_endpoints_out(audio_endpoints_out),
    .host_role_out(host_role_out),
    .bus_power_present_out(bus_power_present_out),
    .attached_out(attached_out)
  );
  // drive levels on an edge, then wait n edges and settle
  task automatic step(input logic r, s, x, v, input int n);
    @(posedge clk_in);
    ready_to_enumerate_in <= r;
    self_powered_in <= s;
    pullup_source_select_key_in <= x;
    vbus <= v;
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the tests need about 450 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    step(1, 0, 0, 0, 100);
    chk(attached_out, 1'b0);
    step(1, 0, 0, 0, 40);
    chk({host_role_out, attached_out,
      internal_pullup_enable_out, audio_endpoints_out,
      max_power_report_out}, 12'h632);
    step(0, 0, 0, 0, 3);
    chk(attached_out, 1'b0);
    $display("bus powered test done");
    step(1, 1, 1, 0, 140);
    chk({pio_oe_out[3], attached_out, pio_out[3]}, 3'b100);
    step(1, 1, 1, 1, 140);
    chk({bus_power_present_out, attached_out, pio_out[3],
      internal_pullup_enable_out}, 4'b1110);
    step(1, 1, 1, 0, 8);
    chk({attached_out, pio_out[3]}, 2'b00);
    $display("self powered test done");
    @(posedge clk_in);
    max_power_override_in <= 1'b1;
    endpoint_set_select_in <= 1'b1;
    step(0, 0, 0, 0, 2);
    chk({audio_endpoints_out, max_power_report_out}, 9'h164);
    $display("power and endpoint test done");
    report_and_stop();
  end
endmodule // tb

// ==== usb_attach_pkg.sv ====
// Purpose: shared constants for the usb attach and power control block
// Assumes: 125 MHz core clock, pio bank width fixed
// Notes: power figures are in 2 mA units as a power descriptor carries them
package usb_attach_pkg;
  localparam int PIO_WIDTH = 16;
  localparam int PIO_SEL_WIDTH = 4;
  localparam int MAX_POWER_WIDTH = 8;
  // default budget of 100 mA, in 2 mA descriptor units
  localparam logic [7:0] DEFAULT_MAX_POWER = 8'h32;
  localparam logic PULLUP_INTERNAL = 1'b0;
  localparam logic PULLUP_EXTERNAL = 1'b1;
  localparam logic ENDPOINTS_WIRELESS = 1'b0;
  localparam logic ENDPOINTS_AUDIO = 1'b1;
  localparam logic [3:0] DEFAULT_SENSE_PIO = 4'h0;
  localparam logic [3:0] DEFAULT_PULLUP_PIO = 4'h1;
  // bus power must be seen steady this long before attach
  localparam int SETTLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_WIDTH = 7;
  typedef enum logic [1:0] {
    ST_DETACHED,
    ST_SETTLING,
    ST_ATTACHED
  } attach_state_t;
endpackage

// ==== usb_attach_power_control.sv ====
// Purpose: decides when the full-speed port attaches, senses bus power,
//   reports the power budget and the endpoint set
// Assumes: configuration ports are steady from core logic on clk_in
// Notes: pio pins arrive from outside and are synchronised before use
//   and in self-powered mode the sense level must hold through a settle window to attach
// Operation
// - full-speed peripheral only, never host
// - pull-up only once ready to enumerate
// - internal or pio pull-up; internal default
// - self-powered: no pull-up without bus power
// - bus sense read from configured pio
// - bus-powered default request is 100 mA
// - reported max power from configurable setting
// - wireless or audio endpoint set selectable
module usb_attach_power_control (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ready_to_enumerate_in,
  input wire logic self_powered_in,
  input wire logic pullup_source_select_key_in,
  input wire logic [3:0] pullup_pio_index_in,
  input wire logic [3:0] bus_power_sense_pin_key_in,
  input wire logic max_power_override_in,
  input wire logic [7:0] max_power_request_key_in,
  input wire logic endpoint_set_select_in,
  input wire logic [15:0] pio_pins_in,
  output logic internal_pullup_enable_out,
  output logic [15:0] pio_out,
  output logic [15:0] pio_oe_out,
  output logic [7:0] max_power_report_out,
  output logic audio_endpoints_out,
  output logic host_role_out,
  output logic bus_power_present_out,
  output logic attached_out
);
  localparam int SETTLE_W = usb_attach_pkg::SETTLE_WIDTH;
  localparam int SETTLE_LAST_INT = usb_attach_pkg::SETTLE_CYCLES - 1;
  localparam int SETTLE_STEP_INT = 1;
  // the settle compare and step are cut to the counter width on purpose
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_LAST_INT[SETTLE_W-1:0];
  localparam logic [SETTLE_W-1:0] SETTLE_STEP = SETTLE_STEP_INT[SETTLE_W-1:0];
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = '0;
  // a pio that this block does not own is left undriven
  localparam logic [usb_attach_pkg::PIO_WIDTH-1:0] PIO_IDLE = '0;

  logic [15:0] pio_sync;
  logic vbus_present;
  logic power_ok;
  logic attach_wanted;
  logic settle_done;
  logic attached_now;
  logic use_external;
  usb_attach_pkg::attach_state_t state_reg;
  usb_attach_pkg::attach_state_t state_next;
  logic [SETTLE_W-1:0] settle_reg;
  logic [SETTLE_W-1:0] settle_next;

  // every pio pin is synchronised; selection happens after the second stage
  genvar gi;
  generate
    for (gi = 0; gi < usb_attach_pkg::PIO_WIDTH; gi++) begin : g_sync
      sync_two_ff u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(pio_pins_in[gi]),
        .sync_out(pio_sync[gi])
      );
    end
  endgenerate

  assign vbus_present = pio_sync[bus_power_sense_pin_key_in];
  // bus-powered designs have power whenever they run at all
  assign power_ok = !self_powered_in || vbus_present;

  // attach is wanted only while firmware is ready and power is present
  assign attach_wanted = ready_to_enumerate_in && power_ok;
  // the settle window closes on its last count, not one later
  assign settle_done = (settle_reg == SETTLE_LAST);
  assign attached_now = (state_reg == usb_attach_pkg::ST_ATTACHED);
  assign use_external =
    (pullup_source_select_key_in == usb_attach_pkg::PULLUP_EXTERNAL);

  // next attach state; losing ready or power leaves at once, with no
  // settle, so in self-powered mode the pull-up drops on the fourth edge after bus power falls
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      usb_attach_pkg::ST_DETACHED: begin
        if (attach_wanted) begin
          state_next = usb_attach_pkg::ST_SETTLING;
        end
      end
      usb_attach_pkg::ST_SETTLING: begin
        if (!attach_wanted) begin
          state_next = usb_attach_pkg::ST_DETACHED;
        end else if (settle_done) begin
          state_next = usb_attach_pkg::ST_ATTACHED;
        end
      end
      usb_attach_pkg::ST_ATTACHED: begin
        if (!attach_wanted) begin
          state_next = usb_attach_pkg::ST_DETACHED;
        end
      end
      // the fourth code of the state is illegal; fall back to detached
      default: begin
        state_next = usb_attach_pkg::ST_DETACHED;
      end
    endcase
  end

  // the settle count runs only while settling and restarts on each entry
  always_comb begin
    settle_next = SETTLE_ZERO;
    if ((state_reg == usb_attach_pkg::ST_SETTLING) && !settle_done) begin
      settle_next = settle_reg + SETTLE_STEP;
    end
  end

  // attach state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= usb_attach_pkg::ST_DETACHED;
    end else begin
      state_reg <= state_next;
    end
  end

  // a short settle filters bounce on the sense pin before attach
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_reg <= SETTLE_ZERO;
    end else begin
      settle_reg <= settle_next;
    end
  end

  // attach flag for firmware, high while the pull-up is asserted
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      attached_out <= 1'b0;
    end else begin
      attached_out <= attached_now;
    end
  end

  // internal pull-up, registered so D+ never glitches; it follows the
  // attach state only while the internal source is chosen
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      internal_pullup_enable_out <= 1'b0;
    end else begin
      internal_pullup_enable_out <= attached_now && !use_external;
    end
  end

  // external pull-up pio enable; held on whenever external mode is
  // chosen so that a detached port pulls D+ low instead of floating
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pio_oe_out <= PIO_IDLE;
    end else begin
      pio_oe_out <= PIO_IDLE;
      if (use_external) begin
        pio_oe_out[pullup_pio_index_in] <= 1'b1;
      end
    end
  end

  // external pull-up level: high on attach, low on detach; a change of
  // the pio index while attached moves the drive at once, so firmware
  // should only change it while detached
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pio_out <= PIO_IDLE;
    end else begin
      pio_out <= PIO_IDLE;
      if (use_external) begin
        pio_out[pullup_pio_index_in] <= attached_now;
      end
    end
  end

  // reported power budget in descriptor units; the default stands
  // unless firmware sets the override, whether the request is larger or smaller
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      max_power_report_out <= usb_attach_pkg::DEFAULT_MAX_POWER;
    end else if (max_power_override_in) begin
      max_power_report_out <= max_power_request_key_in;
    end else begin
      max_power_report_out <= usb_attach_pkg::DEFAULT_MAX_POWER;
    end
  end

  // endpoint set presented at enumeration
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      audio_endpoints_out <= 1'b0;
    end else begin
      audio_endpoints_out <=
        (endpoint_set_select_in == usb_attach_pkg::ENDPOINTS_AUDIO);
    end
  end

  // synchronised sense level, registered on the same edge as the attach state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_power_present_out <= 1'b0;
    end else begin
      bus_power_present_out <= vbus_present;
    end
  end

  // this block only ever acts as a peripheral
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      host_role_out <= 1'b0;
    end else begin
      host_role_out <= 1'b0;
    end
  end
endmodule // usb_attach_power_control
